// >>> inc/twpf_pkg.sv
// types shared by the two-wire packet framer
// assumes nothing beyond the compile order
package twpf_pkg;
  typedef enum logic [1:0] {
    TWPF_CMD_START,
    TWPF_CMD_WRITE,
    TWPF_CMD_READ,
    TWPF_CMD_STOP
  } twpf_cmd_t;
endpackage : twpf_pkg

// >>> inc/twpf_regs.svh
// timing and framing constants of the two-wire packet framer
// assumes the link clock runs the bit engine
`ifndef TWPF_REGS_SVH
`define TWPF_REGS_SVH
`define TWPF_HALF_CYC 16
`define TWPF_ACK_BIT 4'h8
`define TWPF_SYNC_STAGES 2
`endif

// >>> inc/twpf_sync_if.sv
// carrier between the framer and its synchroniser
// assumes d is driven from another domain or a pin
interface twpf_sync_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport syn (input d, output q);
  modport usr (output d, input q);
endinterface : twpf_sync_if

// >>> src/twpf_sync.sv
// two-flop synchroniser for a group of independent levels
// assumes each bit of d is a level or a toggle
module twpf_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // destination clock
  input wire logic rst_i, // async reset, high
  twpf_sync_if.syn port // levels in, synced out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      port.q <= '0;
    end
    else
    begin
      meta <= port.d;
      port.q <= meta;
    end
  end
endmodule : twpf_sync

// >>> src/twpf_top.sv
// two-wire bus master framer: start, packets, stop
// assumes open-drain pads with pull-ups and a free-running link clock
`include "twpf_regs.svh"

// How it works
// - every packet is eight bits plus ack
// - master makes clock, start, stop; receiver acks
// - ack is data held low in ninth clock
// - released data in ninth clock means nack
// - receiver nacks its last wanted byte
// - data bits go out msb first
// - start, address packet, data packets, stop
// - never start directly followed by stop
// - slave may hold clock low; master waits
// - stretching lengthens only low phase
module twpf_top #(
  parameter int HALF_CYC = `TWPF_HALF_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // async reset, high
  input wire logic link_clk_i, // bit engine clock
  input wire logic cmd_valid_i, // command offered
  output logic cmd_ready_o, // command can be taken
  input wire twpf_pkg::twpf_cmd_t cmd_i, // command code
  input wire logic [7:0] cmd_data_i, // address packet or write byte
  input wire logic cmd_ack_i, // read: ack the byte when high
  output logic rsp_valid_o, // one-cycle completion pulse
  output logic [7:0] rsp_data_o, // byte read from the bus
  output logic rsp_nack_o, // write byte was not acknowledged
  output logic rsp_err_o, // command refused, no transmission open
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value
  output logic scl_oe_o, // clock drive enable, low drives
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value
  output logic sda_oe_o // data drive enable, low drives
);
  import twpf_pkg::*;

  localparam int CW = $clog2(HALF_CYC + 1);

  typedef enum {
    L_WAIT,
    L_RS_LOW,
    L_RS_HIGH,
    L_START,
    L_LOW,
    L_RISE,
    L_HIGH,
    L_STOP_LOW,
    L_STOP_RISE,
    L_STOP_HIGH,
    L_BUS_FREE
  } twpf_state_t;

  // user-domain command holding
  twpf_cmd_t hold_cmd;
  logic [7:0] hold_data;
  logic hold_ack;
  logic req_tgl;
  logic busy;
  logic ack_seen;

  // link-domain state
  twpf_state_t state;
  logic [CW-1:0] cnt;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic is_read;
  logic scl_low;
  logic sda_low;
  logic owned;
  logic req_seen;
  logic done_tgl;
  logic [7:0] res_data;
  logic res_nack;
  logic res_err;
  logic link_rst_a;
  logic link_rst;

  logic req_s;
  logic scl_s;
  logic sda_s;
  logic ack_s;
  logic cnt_zero;

  twpf_sync_if #(.W(3)) lk_if ();
  twpf_sync_if #(.W(1)) us_if ();

  assign lk_if.d = {req_tgl, scl_i, sda_i};
  assign us_if.d = done_tgl;

  twpf_sync #(.W(3)) u_lk_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .port(lk_if.syn)
  );

  twpf_sync #(.W(1)) u_us_sync (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .port(us_if.syn)
  );

  assign req_s = lk_if.q[2];
  assign scl_s = lk_if.q[1];
  assign sda_s = lk_if.q[0];
  assign ack_s = us_if.q[0];

  // whether to pull data low during the low phase of bit n
  function automatic logic pull_sda(input logic rd, input logic [3:0] n,
                                    input logic [7:0] sh, input logic ack);
    if (n == `TWPF_ACK_BIT)
      pull_sda = rd & ack;
    else
      pull_sda = ~rd & ~sh[7];
  endfunction : pull_sda

  // ---------------- user domain ----------------
  assign cmd_ready_o = ~busy;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_cmd <= TWPF_CMD_STOP;
      hold_data <= 8'h00;
      hold_ack <= 1'b0;
      req_tgl <= 1'b0;
      busy <= 1'b0;
    end
    else if (cmd_valid_i && !busy)
    begin
      hold_cmd <= cmd_i;
      hold_data <= cmd_data_i;
      hold_ack <= cmd_ack_i;
      req_tgl <= ~req_tgl;
      busy <= 1'b1;
    end
    else if (ack_s != ack_seen)
      busy <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_seen <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_nack_o <= 1'b0;
      rsp_err_o <= 1'b0;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (ack_s != ack_seen)
      begin
        // link results are stable until the next request
        ack_seen <= ack_s;
        rsp_valid_o <= 1'b1;
        rsp_data_o <= res_data;
        rsp_nack_o <= res_nack;
        rsp_err_o <= res_err;
      end
    end
  end

  // ---------------- link domain ----------------
  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      link_rst_a <= 1'b1;
      link_rst <= 1'b1;
    end
    else
    begin
      link_rst_a <= 1'b0;
      link_rst <= link_rst_a;
    end
  end

  assign cnt_zero = (cnt == '0);

  always_ff @(posedge link_clk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      state <= L_WAIT;
      cnt <= '0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      owned <= 1'b0;
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
      res_data <= 8'h00;
      res_nack <= 1'b0;
      res_err <= 1'b0;
    end
    else
    begin
      if (!cnt_zero)
        cnt <= cnt - 1'b1;
      case (state)
        L_WAIT:
        begin
          if (req_s != req_seen)
          begin
            req_seen <= req_s;
            res_err <= 1'b0;
            res_nack <= 1'b0;
            cnt <= CW'(HALF_CYC);
            bitn <= 4'h0;
            shreg <= hold_data;
            is_read <= (hold_cmd == TWPF_CMD_READ);
            case (hold_cmd)
              TWPF_CMD_START:
              begin
                // start always carries the address packet
                is_read <= 1'b0;
                if (owned)
                begin
                  sda_low <= 1'b0;
                  state <= L_RS_LOW;
                end
                else
                begin
                  sda_low <= 1'b1;
                  state <= L_START;
                end
              end
              TWPF_CMD_STOP:
              begin
                if (owned)
                begin
                  sda_low <= 1'b1;
                  state <= L_STOP_LOW;
                end
                else
                  done_tgl <= ~done_tgl;
              end
              default:
              begin
                if (owned)
                  state <= L_LOW;
                else
                begin
                  // data packet outside a transmission is refused
                  res_err <= 1'b1;
                  done_tgl <= ~done_tgl;
                end
              end
            endcase
          end
        end
        L_RS_LOW:
        begin
          if (cnt_zero)
          begin
            scl_low <= 1'b0;
            state <= L_RS_HIGH;
          end
        end
        L_RS_HIGH:
        begin
          if (!scl_s)
            cnt <= CW'(HALF_CYC);
          else if (cnt_zero)
          begin
            sda_low <= 1'b1;
            cnt <= CW'(HALF_CYC);
            state <= L_START;
          end
        end
        L_START:
        begin
          if (cnt_zero)
          begin
            scl_low <= 1'b1;
            owned <= 1'b1;
            cnt <= CW'(HALF_CYC);
            state <= L_LOW; // address packet follows
          end
        end
        L_LOW:
        begin
          // data changes only while the clock is held low
          sda_low <= pull_sda(is_read, bitn, shreg, hold_ack);
          if (cnt_zero)
          begin
            scl_low <= 1'b0;
            state <= L_RISE;
          end
        end
        L_RISE:
        begin
          // slave may stretch the low phase here
          if (scl_s)
          begin
            cnt <= CW'(HALF_CYC);
            state <= L_HIGH;
          end
        end
        L_HIGH:
        begin
          if (cnt_zero)
          begin
            scl_low <= 1'b1;
            cnt <= CW'(HALF_CYC);
            if (bitn == `TWPF_ACK_BIT)
            begin
              // ninth clock closes the packet
              res_nack <= ~is_read & sda_s;
              res_data <= shreg;
              done_tgl <= ~done_tgl;
              state <= L_WAIT;
            end
            else
            begin
              // same shift sends msb first and collects read bits
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'h1;
              state <= L_LOW;
            end
          end
        end
        L_STOP_LOW:
        begin
          if (cnt_zero)
          begin
            scl_low <= 1'b0;
            state <= L_STOP_RISE;
          end
        end
        L_STOP_RISE:
        begin
          if (scl_s)
          begin
            cnt <= CW'(HALF_CYC);
            state <= L_STOP_HIGH;
          end
        end
        L_STOP_HIGH:
        begin
          if (cnt_zero)
          begin
            sda_low <= 1'b0;
            cnt <= CW'(HALF_CYC);
            state <= L_BUS_FREE;
          end
        end
        L_BUS_FREE:
        begin
          if (cnt_zero)
          begin
            owned <= 1'b0;
            done_tgl <= ~done_tgl;
            state <= L_WAIT;
          end
        end
        default:
          state <= L_WAIT;
      endcase
    end
  end

  // open-drain pads: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = ~scl_low;
  assign sda_oe_o = ~sda_low;
endmodule : twpf_top

// >>> verif/tb_two_wire_packet_framing.sv
// self-checking bench for the framer against a behavioural slave
// assumes pull-ups on both lines; link clock 32 ns, unrelated phase
module tb_two_wire_packet_framing;
  timeunit 1ns;
  timeprecision 100ps;
  import twpf_pkg::*;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  twpf_cmd_t cmd_i = TWPF_CMD_STOP;
  logic [7:0] cmd_data_i = 8'h00;
  logic cmd_ack_i = 1'b0;
  logic cmd_ready_o, rsp_valid_o, rsp_nack_o, rsp_err_o, mack;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_low, sda_low;
  logic [7:0] rsp_data_o, got;
  logic [7:0] rd_byte = 8'hC3;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  int pkts, p;
  int fail_count = 0;
  int check_count = 0;
  wire logic scl_i = (scl_oe_o | scl_o) & !scl_low;
  wire logic sda_i = (sda_oe_o | sda_o) & !sda_low;
  always #10 clk_i = !clk_i;
  initial
  begin
    #7;
    forever #16 link_clk_i = !link_clk_i;
  end
  twpf_top #(.HALF_CYC(2)) twpf_top_i (
    .clk_i, .sys_rst_i, .link_clk_i, .cmd_valid_i, .cmd_ready_o, .cmd_i, .cmd_data_i,
    .cmd_ack_i, .rsp_valid_o, .rsp_data_o, .rsp_nack_o, .rsp_err_o, .scl_i, .scl_o,
    .scl_oe_o, .sda_i, .sda_o, .sda_oe_o
  );
  twpf_slave_model twpf_slave_model_i (
    .scl_i, .sda_i, .rd_byte_i(rd_byte), .nack_i(nack), .stretch_i(stretch),
    .scl_low_o(scl_low), .sda_low_o(sda_low), .got_o(got), .mack_o(mack), .pkts_o(pkts)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic cmd(input twpf_cmd_t c, input logic [7:0] d, input logic a);
    int k;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    cmd_data_i <= d;
    cmd_ack_i <= a;
    @(negedge clk_i);
    for (k = 0; k < 9000 && cmd_ready_o !== 1'b1; k++)
      @(negedge clk_i);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    for (; k < 9000 && rsp_valid_o !== 1'b1; k++)
      @(negedge clk_i);
    if (k == 9000)
    begin
      fail_count++;
      $display("MISMATCH %0t command timed out", $time);
      final_report();
    end
  endtask : cmd
  task automatic t_refuse();
    p = pkts;
    cmd(TWPF_CMD_WRITE, 8'h12, 1'b0);
    chk(rsp_err_o, 1'b1);
    cmd(TWPF_CMD_READ, 8'h00, 1'b1);
    chk(rsp_err_o, 1'b1);
    cmd(TWPF_CMD_STOP, 8'h00, 1'b0);
    chk({rsp_err_o, rsp_nack_o, scl_i, sda_i}, 4'h3);
    chk(8'(pkts - p), 8'h00);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_write();
    stretch <= 1'b1;
    cmd(TWPF_CMD_START, 8'hA4, 1'b0);
    chk({got, rsp_nack_o}, {8'hA4, 1'b0});
    p = pkts;
    cmd(TWPF_CMD_WRITE, 8'h5B, 1'b0);
    chk(got, 8'h5B);
    chk(rsp_data_o, 8'h5B);
    nack <= 1'b1;
    cmd(TWPF_CMD_WRITE, 8'h81, 1'b0);
    chk(rsp_nack_o, 1'b1);
    chk(8'(pkts - p), 8'h02);
    nack <= 1'b0;
    stretch <= 1'b0;
    cmd(TWPF_CMD_STOP, 8'h00, 1'b0);
    chk({rsp_err_o, rsp_nack_o, scl_i, sda_i}, 4'h3);
    $display("t_write done");
  endtask : t_write
  task automatic t_read();
    cmd(TWPF_CMD_START, 8'hA4, 1'b0);
    cmd(TWPF_CMD_START, 8'hA5, 1'b0);
    cmd(TWPF_CMD_READ, 8'h00, 1'b1);
    chk({rsp_data_o, mack}, {8'hC3, 1'b1});
    rd_byte <= 8'h96;
    cmd(TWPF_CMD_READ, 8'h00, 1'b0);
    chk({rsp_data_o, mack}, {8'h96, 1'b0});
    cmd(TWPF_CMD_STOP, 8'h00, 1'b0);
    chk({scl_i, sda_i}, 2'b11);
    $display("t_read done");
  endtask : t_read
  initial
  begin
    repeat (16) @(posedge clk_i);
    chk({cmd_ready_o, scl_oe_o, sda_oe_o, rsp_valid_o}, 4'hE);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_refuse();
    t_write();
    t_read();
    final_report();
  end
endmodule : tb_two_wire_packet_framing

// >>> verif/twpf_slave_model.sv
// behavioural slave on the two-wire bus: acks, serves reads, stretches
// assumes pulled-up wire levels; it only ever pulls lines low
module twpf_slave_model (
  input wire logic scl_i, // clock wire
  input wire logic sda_i, // data wire
  input wire logic [7:0] rd_byte_i, // byte served on reads
  input wire logic nack_i, // refuse received bytes
  input wire logic stretch_i, // hold clock low after falls
  output logic scl_low_o = 1'b0, // pull clock low
  output logic sda_low_o = 1'b0, // pull data low
  output logic [7:0] got_o = 8'h00, // last byte received
  output logic mack_o = 1'b1, // master ack of read byte
  output int pkts_o = 0 // nine-bit packets seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00;
  logic rd = 1'b0;
  logic first = 1'b0;
  always @(negedge sda_i)
    if (scl_i)
    begin
      n = 4'h0;
      first = 1'b1;
      rd = 1'b0;
      mack_o = 1'b1;
    end
  always @(posedge scl_i)
  begin
    if (n < 4'h8)
      sh = {sh[6:0], sda_i};
    else
      mack_o = !sda_i;
    n = n + 4'h1;
  end
  always @(negedge scl_i)
  begin
    sda_low_o = 1'b0;
    if (n == 4'h9)
    begin
      n = 4'h0;
      pkts_o = pkts_o + 1;
      first = 1'b0;
    end
    if (n == 4'h8 && (first || !rd))
    begin
      got_o = sh;
      rd = first & sh[0];
      sda_low_o = !nack_i;
    end
    else if (rd && !first && mack_o && n < 4'h8)
      sda_low_o = !rd_byte_i[3'd7 - n[2:0]];
    if (stretch_i)
    begin
      scl_low_o = 1'b1;
      #500 scl_low_o = 1'b0;
    end
  end
endmodule : twpf_slave_model

// >>> verif/twpf_top_props.sv
// checker for the framer's command handshake and bus line drive
// assumes binding to twpf_top; line checks run on the link clock
module twpf_top_props #(
  parameter int HALF_CYC = 16
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // async reset
  input wire logic link_clk_i, // link clock
  input wire logic cmd_valid_i, // command offered
  input wire logic cmd_ready_o, // command accepted
  input wire logic rsp_valid_o, // done pulse
  input wire logic [7:0] rsp_data_o, // read byte
  input wire logic rsp_nack_o, // nack flag
  input wire logic rsp_err_o, // refusal flag
  input wire logic scl_i, // clock line
  input wire logic scl_o, // clock value
  input wire logic scl_oe_o, // clock enable
  input wire logic sda_o // data value
);
  timeunit 1ns;
  timeprecision 100ps;
  chk_ready_on_rsp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o |-> cmd_ready_o) else $error("ready low at response");
  chk_rsp_one_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o |=> !rsp_valid_o) else $error("response pulse too long");
  chk_busy_after_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o) else $error("ready after take");
  chk_idle_stays_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_ready_o && !cmd_valid_i |=> cmd_ready_o) else $error("ready dropped");
  chk_rsp_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rsp_valid_o |-> $stable({rsp_data_o, rsp_nack_o, rsp_err_o})) else $error("rsp moved");
  chk_open_drain_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    !scl_o && !sda_o) else $error("line driven high");
  chk_stretch_wait: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    scl_oe_o && !scl_i |=> scl_oe_o) else $error("clock pulled while held");
  chk_high_from_seen: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    scl_oe_o && $rose(scl_i) |=> scl_oe_o [*4]) else $error("clock high too short");
  cov_nack: cover property (@(posedge clk_i) rsp_valid_o && rsp_nack_o);
  cov_err: cover property (@(posedge clk_i) rsp_valid_o && rsp_err_o);
  cov_stretch: cover property (@(posedge link_clk_i) scl_oe_o && !scl_i);
endmodule : twpf_top_props

bind twpf_top twpf_top_props #(.HALF_CYC(HALF_CYC)) twpf_top_props_i (
  .clk_i, .sys_rst_i, .link_clk_i, .cmd_valid_i, .cmd_ready_o, .rsp_valid_o,
  .rsp_data_o, .rsp_nack_o, .rsp_err_o, .scl_i, .scl_o, .scl_oe_o, .sda_o
);
